// [rtl/cdrcs_pkg.sv]
package cdrcs_pkg;

    // register offsets
    localparam logic [7:0] OFS_TX_CTRL = 8'h13;
    localparam logic [7:0] OFS_RSVD_FIRST = 8'h14;
    localparam logic [7:0] OFS_RSVD_LAST = 8'h27;
    localparam logic [7:0] OFS_CONV_HIGH = 8'h28;
    localparam logic [7:0] OFS_CONV_LOW = 8'h29;
    localparam logic [7:0] OFS_RX_STATUS = 8'h2a;

    // reset and fill values
    localparam logic [7:0] TX_CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // transmit recovery control fields
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_FORCE_ON = 5;
    localparam int CTRL_FORCE_OFF = 4;
    localparam int CTRL_QUICK_OFF = 3;
    localparam int CTRL_DIV_HI = 2;
    localparam int CTRL_DIV_LO = 0;
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_FIXED_LOW = 2'h1;
    localparam logic [1:0] MODE_FIXED_HIGH = 2'h2;
    localparam logic [2:0] DIV_FULL = 3'h0;
    localparam logic [2:0] DIV_MAX_CODE = 3'h5;

    // receive status fields
    localparam int ST_UNLOCKED_LIVE = 7;
    localparam int ST_LOCK_LATCHED = 6;
    localparam int ST_LOST_LIVE = 5;
    localparam int ST_LOST_LATCHED = 4;

    // converter result split
    localparam int CONV_W = 10;
    localparam int CONV_LOW_BITS = 2;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        CDRCS_AUTO,
        CDRCS_FIXED_LOW,
        CDRCS_FIXED_HIGH,
        CDRCS_TEST
    } cdrcs_rate_mode_t;

    typedef struct packed {
        cdrcs_rate_mode_t mode;
        logic detector_on;
        logic quick_acquire;
        logic [2:0] div_log2;
    } cdrcs_cdr_ctrl_t;

    typedef struct packed {
        logic unlocked;
        logic signal_lost;
    } cdrcs_rx_live_t;

endpackage

// [rtl/cdrcs_flag_latch.sv]
`timescale 1ns/1ps
`default_nettype none

module cdrcs_flag_latch #(
    parameter logic ACTIVE = 1'b1
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_sync_b,
    input wire logic i_clk_en,
    // live flag and read strobe
    input wire logic i_live,
    input wire logic i_read_clear,
    // sticky copy
    output logic o_latched
);

    logic live_q;
    logic next_live_q;
    logic next_latched;

    always_comb begin
        next_live_q = i_live;
        next_latched = o_latched;
        // a read re-arms the latch from the live level
        if (i_read_clear) begin
            next_latched = i_live;
        end
        // an edge in the read cycle still lands: set beats clear
        if (i_live == ACTIVE && live_q != ACTIVE) begin
            next_latched = ACTIVE;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_sync_b) begin
        if (!i_rst_sync_b) begin
            live_q <= 1'b0;
            o_latched <= 1'b0;
        end else if (i_clk_en) begin
            live_q <= next_live_q;
            o_latched <= next_latched;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_sync_b);

    a_edge_latches: assert property (
        (i_clk_en && i_live == ACTIVE && live_q != ACTIVE)
        |=> o_latched == ACTIVE)
        else $error("latched flag missed an active edge");

    c_edge_seen: cover property (
        i_clk_en && i_live == ACTIVE && live_q != ACTIVE);

endmodule

`default_nettype wire

// [rtl/cdrcs_control_status.sv]
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - mode field 00 auto rate, 01 fixed 10.3G, 10 fixed 11.1G.
// - force-on bit 5 keeps the rate detector enabled unless force-off bit 4 is also set.
// - force-off bit 4 keeps the rate detector always disabled.
// - bit 3 low gives fast-lock acquisition; bit 3 high turns it off.
// - divider 000 full rate; 001..101 divide by 2, 4, 8, 16, 32.
// - converter result bits 9:2 in high register, 1:0 in low, rest zero.
// - status bit 7 shows live unlocked state of receive recovery.
// - status bit 6 latches low on lock edge; read re-arms it.
// - status bit 4 latches high on loss edge; read re-arms it.
// - locations 20..39 are reserved, no function, left untouched.
module cdrcs_control_status
    import cdrcs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2c  // arbitrary value
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // two-wire serial port
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // converter and receive status
    input wire logic [CONV_W-1:0] i_conv_result,
    input wire cdrcs_rx_live_t i_rx_live,
    input wire logic i_fd_auto_on,
    // recovery control
    output cdrcs_cdr_ctrl_t o_cdr_ctrl
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } cdrcs_ser_state_t;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial slave
    cdrcs_ser_state_t state;
    cdrcs_ser_state_t next_state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shifter;
    logic [7:0] next_shifter;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic rw;
    logic next_rw;
    logic sda_oe;
    logic next_sda_oe;
    logic wr_stb;
    logic rd_load;
    logic [7:0] read_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic status_clr;
    logic lock_latched;
    logic lost_latched;
    logic [7:0] tx_ctrl;

    assign scl_rise = i_scl && !scl_q;
    assign scl_fall = !i_scl && scl_q;
    assign start_seen = scl_q && i_scl && sda_q && !i_sda;
    assign stop_seen = scl_q && i_scl && !sda_q && i_sda;
    assign status_clr = rd_load && ptr == OFS_RX_STATUS;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shifter = shifter;
        next_ptr = ptr;
        next_rw = rw;
        next_sda_oe = sda_oe;
        wr_stb = 1'b0;
        rd_load = 1'b0;
        if (start_seen) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        next_shifter = {shifter[6:0], i_sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe = 1'b1;
                        case (state)
                            ST_ADDR: begin
                                if (shifter[7:1] == DEV_ADDR) begin
                                    next_rw = shifter[0];
                                    next_state = ST_ADDR_ACK;
                                end else begin
                                    next_state = ST_IDLE;
                                    next_sda_oe = 1'b0;
                                end
                            end
                            ST_REG: begin
                                next_ptr = shifter;
                                next_state = ST_REG_ACK;
                            end
                            default: begin
                                wr_stb = 1'b1;
                                next_ptr = ptr + 8'h01;
                                next_state = ST_WDATA_ACK;
                            end
                        endcase
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK, ST_RDATA_ACK: begin
                    // a master nack ends the read burst
                    if (state == ST_RDATA_ACK && scl_rise && i_sda) begin
                        next_state = ST_IDLE;
                    end else if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        if (state == ST_REG_ACK || state == ST_WDATA_ACK) begin
                            next_state = ST_WDATA;
                        end else if (state == ST_ADDR_ACK && !rw) begin
                            next_state = ST_REG;
                        end else begin
                            rd_load = 1'b1;
                            next_shifter = {read_byte[6:0], 1'b0};
                            next_sda_oe = !read_byte[7];
                            next_bit_cnt = 4'h1;
                            next_ptr = ptr + 8'h01;
                            next_state = ST_RDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            next_sda_oe = 1'b0;
                            next_bit_cnt = 4'h0;
                            next_state = ST_RDATA_ACK;
                        end else begin
                            next_sda_oe = !shifter[7];
                            next_shifter = {shifter[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt <= 4'h0;
            shifter <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            sda_oe <= 1'b0;
        end else if (i_clk_en) begin
            state <= next_state;
            scl_q <= i_scl;
            sda_q <= i_sda;
            bit_cnt <= next_bit_cnt;
            shifter <= next_shifter;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe <= next_sda_oe;
        end
    end

    // open drain: the pin is only ever pulled low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe;

    ////////////////////////////////////////////////////////////////////////
    // read map; converter halves are live, so a slow reader can tear them
    always_comb begin
        read_byte = READ_ZERO;
        case (ptr)
            OFS_TX_CTRL: read_byte = tx_ctrl;
            OFS_CONV_HIGH: begin
                read_byte = i_conv_result[CONV_W-1:CONV_LOW_BITS];
            end
            OFS_CONV_LOW: begin
                read_byte[CONV_LOW_BITS-1:0] =
                    i_conv_result[CONV_LOW_BITS-1:0];
            end
            OFS_RX_STATUS: begin
                read_byte[ST_UNLOCKED_LIVE] = i_rx_live.unlocked;
                read_byte[ST_LOCK_LATCHED] = lock_latched;
                read_byte[ST_LOST_LIVE] = i_rx_live.signal_lost;
                read_byte[ST_LOST_LATCHED] = lost_latched;
            end
            default: read_byte = READ_ZERO;
        endcase
    end

    cdrcs_flag_latch #(.ACTIVE(1'b0)) u_lock_latch (
        .i_ref_clk(i_ref_clk),
        .i_rst_sync_b(rst_sync_b),
        .i_clk_en(i_clk_en),
        .i_live(i_rx_live.unlocked),
        .i_read_clear(status_clr),
        .o_latched(lock_latched)
    );

    cdrcs_flag_latch #(.ACTIVE(1'b1)) u_lost_latch (
        .i_ref_clk(i_ref_clk),
        .i_rst_sync_b(rst_sync_b),
        .i_clk_en(i_clk_en),
        .i_live(i_rx_live.signal_lost),
        .i_read_clear(status_clr),
        .o_latched(lost_latched)
    );

    ////////////////////////////////////////////////////////////////////////
    // control register and decode
    logic [7:0] next_tx_ctrl;
    cdrcs_cdr_ctrl_t next_cdr_ctrl;
    logic [2:0] div_code;

    assign div_code = tx_ctrl[CTRL_DIV_HI:CTRL_DIV_LO];

    always_comb begin
        next_tx_ctrl = tx_ctrl;
        if (wr_stb && ptr == OFS_TX_CTRL)
            next_tx_ctrl = shifter;
        case (tx_ctrl[CTRL_MODE_HI:CTRL_MODE_LO])
            MODE_AUTO: next_cdr_ctrl.mode = CDRCS_AUTO;
            MODE_FIXED_LOW: next_cdr_ctrl.mode = CDRCS_FIXED_LOW;
            MODE_FIXED_HIGH: next_cdr_ctrl.mode = CDRCS_FIXED_HIGH;
            default: next_cdr_ctrl.mode = CDRCS_TEST;
        endcase
        // force-off wins when both force bits are set, the safer state
        if (tx_ctrl[CTRL_FORCE_OFF])
            next_cdr_ctrl.detector_on = 1'b0;
        else if (tx_ctrl[CTRL_FORCE_ON])
            next_cdr_ctrl.detector_on = 1'b1;
        else
            next_cdr_ctrl.detector_on = i_fd_auto_on;
        next_cdr_ctrl.quick_acquire = !tx_ctrl[CTRL_QUICK_OFF];
        if (div_code <= DIV_MAX_CODE)
            next_cdr_ctrl.div_log2 = div_code;
        else
            next_cdr_ctrl.div_log2 = DIV_FULL;
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_ctrl <= TX_CTRL_RESET;
            o_cdr_ctrl <= '0;
        end else if (i_clk_en) begin
            tx_ctrl <= next_tx_ctrl;
            o_cdr_ctrl <= next_cdr_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_sync_b);

    a_mode_fixed_low: assert property (
        (i_clk_en && tx_ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_FIXED_LOW)
        |=> o_cdr_ctrl.mode == CDRCS_FIXED_LOW)
        else $error("mode 01 did not select the low fixed rate");
    a_force_on_holds: assert property (
        (i_clk_en && tx_ctrl[CTRL_FORCE_ON] && !tx_ctrl[CTRL_FORCE_OFF])
        |=> o_cdr_ctrl.detector_on)
        else $error("forced-on detector is off");
    a_force_off_holds: assert property (
        (i_clk_en && tx_ctrl[CTRL_FORCE_OFF]) |=> !o_cdr_ctrl.detector_on)
        else $error("forced-off detector is on");
    a_quick_acquire: assert property (
        i_clk_en
        |=> o_cdr_ctrl.quick_acquire == !$past(tx_ctrl[CTRL_QUICK_OFF]))
        else $error("fast lock does not follow bit 3");
    a_divider_map: assert property (
        (i_clk_en && div_code <= DIV_MAX_CODE)
        |=> o_cdr_ctrl.div_log2 == $past(div_code))
        else $error("divider output differs from code");
    a_ro_write_ignored: assert property (
        (wr_stb && ptr != OFS_TX_CTRL) |=> tx_ctrl == $past(tx_ctrl))
        else $error("write to read-only location changed control");
    a_status_live_bit: assert property (
        (rd_load && i_clk_en && ptr == OFS_RX_STATUS)
        |=> o_sda_oe == !$past(i_rx_live.unlocked))
        else $error("status bit 7 did not show live lock state");
    a_conv_high_bit: assert property (
        (rd_load && i_clk_en && ptr == OFS_CONV_HIGH)
        |=> o_sda_oe == !$past(i_conv_result[CONV_W-1]))
        else $error("high converter byte does not start at bit 9");

    c_ctrl_write: cover property (wr_stb && ptr == OFS_TX_CTRL && i_clk_en);
    c_status_read: cover property (status_clr && i_clk_en);
    c_read_nack: cover property (
        state == ST_RDATA_ACK && scl_rise && i_sda && i_clk_en);

endmodule

`default_nettype wire

// [verification/cdr_control_status_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("BAD %0t %s", $time, msg); \
        end \
    end

module cdr_control_status_regs_test;
    import cdrcs_pkg::*;

    localparam logic [6:0] ADDR = 7'h2c;  // arbitrary value

    logic clk;
    logic rst_b;
    logic clk_en;
    logic scl;
    logic m_sda;
    logic fd_auto;
    logic sda_out;
    logic sda_oe;
    logic [9:0] conv;
    cdrcs_rx_live_t live;
    cdrcs_cdr_ctrl_t ctrl;
    wire logic sda_line;
    int err_total;
    int check_count;
    int seed;
    logic [7:0] rbuf [0:1];
    logic a9;

    // open drain: the device can only pull the shared line low
    assign sda_line = m_sda & ~sda_oe;

    cdrcs_control_status #(
        .DEV_ADDR(ADDR)
    ) cdrcs_control_status_i (
        .i_ref_clk(clk),
        .i_rst_b(rst_b),
        .i_clk_en(clk_en),
        .i_scl(scl),
        .i_sda(sda_line),
        .o_sda_out(sda_out),
        .o_sda_oe(sda_oe),
        .i_conv_result(conv),
        .i_rx_live(live),
        .i_fd_auto_on(fd_auto),
        .o_cdr_ctrl(ctrl)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // each scl phase lasts four clocks, well above the two-clock minimum
    task automatic bit_io(input logic b, output logic r);
        m_sda = b;
        cyc(3);
        scl = 1'b1;
        cyc(2);
        r = sda_line;
        cyc(2);
        scl = 1'b0;
        cyc(1);
    endtask

    task automatic bus_start;
        m_sda = 1'b1;
        cyc(2);
        scl = 1'b1;
        cyc(3);
        m_sda = 1'b0;
        cyc(3);
        scl = 1'b0;
        cyc(2);
    endtask

    task automatic bus_stop;
        m_sda = 1'b0;
        cyc(2);
        scl = 1'b1;
        cyc(3);
        m_sda = 1'b1;
        cyc(4);
    endtask

    // eight data bits msb first, then the ninth bit at level last
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] r);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            r[i] = b;
        end
        bit_io(last, a9);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
        logic [7:0] r;
        bus_start;
        xfer({ADDR, 1'b0}, 1'b1, r);
        `CHK(a9, 1'b0, "write address not acked")
        xfer(ofs, 1'b1, r);
        xfer(val, 1'b1, r);
        bus_stop;
    endtask

    // master acks every byte but the last, which it nacks
    task automatic rd(input logic [7:0] ofs, input int n);
        logic [7:0] r;
        bus_start;
        xfer({ADDR, 1'b0}, 1'b1, r);
        xfer(ofs, 1'b1, r);
        bus_start;
        xfer({ADDR, 1'b1}, 1'b1, r);
        `CHK(a9, 1'b0, "read address not acked")
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, r);
            rbuf[k] = r;
        end
        bus_stop;
    endtask

    function automatic cdrcs_cdr_ctrl_t exp_ctrl(input logic [7:0] v,
                                                 input logic au);
        cdrcs_cdr_ctrl_t e;
        e.mode = cdrcs_rate_mode_t'(v[7:6]);
        e.detector_on = v[4] ? 1'b0 : (v[5] ? 1'b1 : au);
        e.quick_acquire = ~v[3];
        e.div_log2 = (v[2:0] > 3'h5) ? 3'h0 : v[2:0];
        return e;
    endfunction

    function automatic logic [7:0] exp_status(input cdrcs_rx_live_t l);
        return {l.unlocked, l.unlocked, l.signal_lost, l.signal_lost, 4'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        logic [7:0] r;
        seed = 36;
        err_total = 0;
        check_count = 0;
        clk_en = 1'b1;
        scl = 1'b1;
        m_sda = 1'b1;
        fd_auto = 1'b0;
        conv = 10'h000;
        live = 2'b00;
        rst_b = 1'b0;
        cyc(16);
        rst_b = 1'b1;
        cyc(6);
        `CHK(ctrl, exp_ctrl(8'h00, 1'b0), "reset decode")
        `CHK(sda_out, 1'b0, "sda output level not low")
        `CHK(sda_oe, 1'b0, "sda driven after reset")
        rd(8'h13, 1);
        `CHK(rbuf[0], 8'h00, "control reset value")
        // legal modes only; test code 11 is never written
        for (int i = 0; i < 18; i++) begin
            v[7:6] = 2'(i % 3);
            v[5:3] = 3'($random(seed));
            v[2:0] = 3'(i % 6);
            fd_auto = 1'($random(seed));
            wr(8'h13, v);
            `CHK(ctrl, exp_ctrl(v, fd_auto), "decode")
            rd(8'h13, 1);
            `CHK(rbuf[0], v, "control readback")
        end
        wr(8'h13, 8'h00);
        fd_auto = 1'b1;
        cyc(3);
        `CHK(ctrl.detector_on, 1'b1, "auto detector on")
        clk_en = 1'b0;
        fd_auto = 1'b0;
        cyc(4);
        `CHK(ctrl.detector_on, 1'b1, "state moved while frozen")
        clk_en = 1'b1;
        cyc(3);
        `CHK(ctrl.detector_on, 1'b0, "auto detector off")
        // foreign address must stay unanswered
        bus_start;
        xfer({~ADDR, 1'b0}, 1'b1, r);
        `CHK(a9, 1'b1, "foreign address acked")
        bus_stop;
        // writes to read-only and reserved places are dropped
        wr(8'h13, 8'h49);
        wr(8'h28, 8'hff);
        wr(8'h29, 8'hff);
        wr(8'h2a, 8'hff);
        v = 8'h14 + 8'(($random(seed) & 32'h7fff) % 20);
        wr(v, 8'hff);
        rd(8'h13, 1);
        `CHK(rbuf[0], 8'h49, "control hit by other write")
        rd(v, 1);
        `CHK(rbuf[0], 8'h00, "reserved read")
        // converter result read as a pair through the auto-increment
        for (int i = 0; i < 6; i++) begin
            conv = (i == 0) ? 10'h3ff : 10'($random(seed));
            rd(8'h28, 2);
            `CHK(rbuf[0], conv[9:2], "converter high")
            `CHK(rbuf[1], {6'h00, conv[1:0]}, "converter low")
        end
        // status latches: short glitches on the live flags
        live = 2'b10;
        cyc(3);
        rd(8'h2a, 1);
        rd(8'h2a, 1);
        `CHK(rbuf[0], 8'hc0, "status unlocked")
        live.unlocked = 1'b0;
        cyc(3);
        live.unlocked = 1'b1;
        cyc(3);
        rd(8'h2a, 1);
        `CHK(rbuf[0], 8'h80, "lock latch not held low")
        rd(8'h2a, 1);
        `CHK(rbuf[0], 8'hc0, "lock latch not re-armed")
        live.signal_lost = 1'b1;
        cyc(3);
        live.signal_lost = 1'b0;
        cyc(3);
        rd(8'h2a, 1);
        `CHK(rbuf[0], 8'hd0, "loss latch not held high")
        rd(8'h2a, 1);
        `CHK(rbuf[0], 8'hc0, "loss latch not re-armed")
        for (int i = 0; i < 6; i++) begin
            live = (i == 0) ? 2'b01 : 2'($random(seed));
            cyc(3);
            rd(8'h2a, 1);
            rd(8'h2a, 1);
            `CHK(rbuf[0], exp_status(live), "live status")
        end
        summarize;
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        summarize;
    end
endmodule

`default_nettype wire
